/* File: hdl/gpi_pkg.sv */
// Constants, types and helpers shared by the port interrupt block
package gpi_pkg;

	// ************************************************
	// Widths
	// ************************************************
	localparam int unsigned PORT_W = 8;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned TRIG_PIN = 4;

	// ************************************************
	// Register offsets (byte addresses)
	// ************************************************
	localparam logic [11:0] OFF_DIR = 12'h400;
	localparam logic [11:0] OFF_SENSE = 12'h404;
	localparam logic [11:0] OFF_BOTH = 12'h408;
	localparam logic [11:0] OFF_POL = 12'h40C;
	localparam logic [11:0] OFF_MASK = 12'h410;
	localparam logic [11:0] OFF_RAW = 12'h414;
	localparam logic [11:0] OFF_MIS = 12'h418;
	localparam logic [11:0] OFF_CLR = 12'h41C;
	localparam logic [11:0] OFF_FUNC = 12'h420;

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_SENSE = 8'h00;
	localparam logic [7:0] RST_BOTH = 8'h00;
	localparam logic [7:0] RST_POL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_STAT = 8'h00;
	localparam logic [7:0] FUNC_RST_PORT_B = 8'h80;
	localparam logic [7:0] FUNC_RST_PORT_C = 8'h0F;
	localparam logic [7:0] FUNC_RST_OTHER = 8'h00;

	// ************************************************
	// Bus encodings
	// ************************************************
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [23:0] RSVD_ZERO = 24'h000000;
	localparam logic [31:0] RDATA_ZERO = 32'h00000000;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WRITE,
		PH_READ_WAIT,
		PH_READ_DONE
	} gpi_phase_e;

	typedef struct packed {
		logic hsel;
		logic [11:0] addr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
	} gpi_ahb_req_s;

	typedef struct packed {
		logic en;
		logic [11:0] addr;
		logic [7:0] data;
	} gpi_wr_s;

	// Word match; byte lanes below bit 2 are ignored
	function automatic logic gpi_hit(input logic [11:0] a, input logic [11:0] off);
		return a[11:2] == off[11:2];
	endfunction

endpackage

/* File: hdl/gpi_ahb_if.sv */
// AHB-Lite slave front end: phase tracking, write strobe, registered read data
`timescale 1ns/10ps
`default_nettype none
module gpi_ahb_if
	import gpi_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire gpi_ahb_req_s i_req,
	input wire logic [31:0] i_hwdata,
	input wire logic [7:0] i_rdata,
	output gpi_wr_s o_wr,
	output logic [11:0] o_rd_addr,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata
);
	gpi_phase_e ph_q;
	gpi_phase_e ph_d;
	logic [11:0] addr_q;
	logic [31:0] hrdata_q;
	logic take;

	assign take = i_req.hsel & i_req.htrans[1] & i_req.hready;

	// Reads take one wait state so the read sees a write just completed
	always_comb begin
		if (take) begin
			ph_d = i_req.hwrite ? PH_WRITE : PH_READ_WAIT;
		end else if (ph_q == PH_READ_WAIT) begin
			ph_d = PH_READ_DONE;
		end else begin
			ph_d = PH_IDLE;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ph_q <= PH_IDLE;
		end else begin
			ph_q <= ph_d;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			addr_q <= 12'h000;
		end else if (take) begin
			addr_q <= i_req.addr;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hrdata_q <= RDATA_ZERO;
		end else if (ph_q == PH_READ_WAIT) begin
			hrdata_q <= {RSVD_ZERO, i_rdata};
		end
	end

	assign o_wr.en = ph_q == PH_WRITE;
	assign o_wr.addr = addr_q;
	assign o_wr.data = i_hwdata[7:0];
	assign o_rd_addr = addr_q;
	assign o_hreadyout = ph_q != PH_READ_WAIT;
	assign o_hrdata = hrdata_q;
endmodule
`default_nettype wire

/* File: hdl/gpi_onset.sv */
// One-cycle registered pulse on the rising edge of a level
`timescale 1ns/10ps
`default_nettype none
module gpi_onset (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_level,
	output logic o_pulse
);
	logic level_q;
	logic pulse_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			level_q <= 1'b0;
		end else begin
			level_q <= i_level;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= i_level & ~level_q;
		end
	end

	assign o_pulse = pulse_q;
endmodule
`default_nettype wire

/* File: hdl/gpi_top.sv */
// Port interrupt detection, pin function select and register file
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Sense bit 1 selects level detection, 0 selects edge detection.
// - In edge mode, both-edge bit 1 flags every rising and falling edge.
// - Both-edge bit 0 uses the polarity bit for single edge or level.
// - Polarity 1 means rising edge or high level.
// - Polarity 0 means falling edge or low level.
// - Mask bit 1 routes the pin condition to its irq and combined line.
// - Mask bit 0 blocks the pin; status and all config fields except function reset to zero.
// - Raw status shows detected conditions regardless of the mask.
// - Masked status equals raw status AND mask, per pin.
// - Writing 1 to clear drops that edge latch; 0 does nothing; reads zero.
// - Function bit 1 gives the pin to hardware, 0 keeps software I/O.
// - Function bits reset to zero except debug pins, which reset to one.
// - Any reset restores direction and function settings to defaults.
// - Pin 4 of port B, when unmasked, also pulses the converter trigger.
// - Fields sit in bits 7 to 0; bits 31 to 8 read zero.
module gpi_top
	import gpi_pkg::*;
#(
	parameter logic [7:0] P_FUNC_RST = FUNC_RST_PORT_B,
	parameter logic P_HAS_TRIG = 1'b1
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	output logic [31:0] O_HRDATA,
	input wire logic [7:0] I_PIN,
	output logic [7:0] O_PIN_DIR,
	output logic [7:0] O_HW_FUNC,
	output logic [7:0] O_PIN_IRQ,
	output logic O_PORT_IRQ,
	output logic O_CONV_TRIG
);

	// ************************************************
	// Declarations
	// ************************************************
	gpi_ahb_req_s req;
	gpi_wr_s wr;
	logic [11:0] rd_addr;
	logic [7:0] rdata;
	logic wr_dir;
	logic wr_sense;
	logic wr_both;
	logic wr_pol;
	logic wr_mask;
	logic wr_clr;
	logic wr_func;
	logic [7:0] dir_q;
	logic [7:0] sense_q;
	logic [7:0] both_q;
	logic [7:0] pol_q;
	logic [7:0] mask_q;
	logic [7:0] func_q;
	logic [7:0] prev_q;
	logic armed_q;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] single_hit;
	logic [7:0] edge_hit;
	logic [7:0] lvl_hit;
	logic [7:0] edge_q;
	logic [7:0] lvl_q;
	logic [7:0] clr;
	logic [7:0] raw;
	logic [7:0] masked_status_bits;
	logic trig_src;

	// ************************************************
	// Bus front end
	// ************************************************
	assign req.hsel = I_HSEL;
	assign req.addr = I_HADDR[11:0];
	assign req.htrans = I_HTRANS;
	assign req.hwrite = I_HWRITE;
	assign req.hsize = I_HSIZE;
	assign req.hready = I_HREADY;

	gpi_ahb_if u_bus (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_req(req),
		.i_hwdata(I_HWDATA),
		.i_rdata(rdata),
		.o_wr(wr),
		.o_rd_addr(rd_addr),
		.o_hreadyout(O_HREADYOUT),
		.o_hrdata(O_HRDATA)
	);

	// Every transfer is answered OKAY, unmapped ones included
	assign O_HRESP = HRESP_OKAY;

	// ************************************************
	// Write decode
	// ************************************************
	assign wr_dir = wr.en & gpi_hit(wr.addr, OFF_DIR);
	assign wr_sense = wr.en & gpi_hit(wr.addr, OFF_SENSE);
	assign wr_both = wr.en & gpi_hit(wr.addr, OFF_BOTH);
	assign wr_pol = wr.en & gpi_hit(wr.addr, OFF_POL);
	assign wr_mask = wr.en & gpi_hit(wr.addr, OFF_MASK);
	assign wr_clr = wr.en & gpi_hit(wr.addr, OFF_CLR);
	assign wr_func = wr.en & gpi_hit(wr.addr, OFF_FUNC);

	// ************************************************
	// Configuration registers
	// ************************************************
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			dir_q <= RST_DIR;
		end else if (wr_dir) begin
			dir_q <= wr.data;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			sense_q <= RST_SENSE;
		end else if (wr_sense) begin
			sense_q <= wr.data;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			both_q <= RST_BOTH;
		end else if (wr_both) begin
			both_q <= wr.data;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pol_q <= RST_POL;
		end else if (wr_pol) begin
			pol_q <= wr.data;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			mask_q <= RST_MASK;
		end else if (wr_mask) begin
			mask_q <= wr.data;
		end
	end

	// Debug pins come up in hardware mode so a debugger can attach
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			func_q <= P_FUNC_RST;
		end else if (wr_func) begin
			func_q <= wr.data;
		end
	end

	assign O_PIN_DIR = dir_q;
	assign O_HW_FUNC = func_q;

	// ************************************************
	// Edge and level detection
	// ************************************************
	// Pin history is only trusted after one sample, so a pin already
	// high at reset release is not taken as a rising edge.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			prev_q <= 8'h00;
		end else begin
			prev_q <= I_PIN;
		end
	end

	assign rise = I_PIN & ~prev_q & {PORT_W{armed_q}};
	assign fall = ~I_PIN & prev_q & {PORT_W{armed_q}};

	// Polarity picks the single edge when both-edge is off
	assign single_hit = (pol_q & rise) | (~pol_q & fall);

	// Edge mode only; both-edge overrides polarity
	assign edge_hit = ~sense_q & ((both_q & (rise | fall)) | (~both_q & single_hit));

	// Level mode: pin equals polarity
	assign lvl_hit = sense_q & ~(I_PIN ^ pol_q);

	assign clr = wr_clr ? wr.data : 8'h00;

	// New edge wins over a clear in the same cycle; latch dropped in level mode
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			edge_q <= RST_STAT;
		end else begin
			edge_q <= edge_hit | (edge_q & ~clr & ~sense_q);
		end
	end

	// Level status is not latched: it follows the pin
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			lvl_q <= RST_STAT;
		end else begin
			lvl_q <= lvl_hit;
		end
	end

	// ************************************************
	// Status and interrupt outputs
	// ************************************************
	assign raw = (sense_q & lvl_q) | (~sense_q & edge_q);
	assign masked_status_bits = raw & mask_q;

	assign O_PIN_IRQ = masked_status_bits;
	assign O_PORT_IRQ = |masked_status_bits;

	// ************************************************
	// Converter trigger
	// ************************************************
	// Pulse only at onset; a held level condition does not retrigger
	assign trig_src = P_HAS_TRIG & masked_status_bits[TRIG_PIN];

	gpi_onset u_trig (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_level(trig_src),
		.o_pulse(O_CONV_TRIG)
	);

	// ************************************************
	// Read mux
	// ************************************************
	// Clear register and unmapped words read as zero
	always_comb begin
		unique case (rd_addr[11:2])
			OFF_DIR[11:2]: begin
				rdata = dir_q;
			end
			OFF_SENSE[11:2]: begin
				rdata = sense_q;
			end
			OFF_BOTH[11:2]: begin
				rdata = both_q;
			end
			OFF_POL[11:2]: begin
				rdata = pol_q;
			end
			OFF_MASK[11:2]: begin
				rdata = mask_q;
			end
			OFF_RAW[11:2]: begin
				rdata = raw;
			end
			OFF_MIS[11:2]: begin
				rdata = masked_status_bits;
			end
			OFF_FUNC[11:2]: begin
				rdata = func_q;
			end
			default: begin
				rdata = 8'h00;
			end
		endcase
	end

endmodule
`default_nettype wire

/* File: sim/gpi_top_assertions.sv */
// Port-level checker for the port interrupt block
`timescale 1ns/10ps
`default_nettype none
module gpi_top_chk
	import gpi_pkg::*;
#(
	parameter logic [7:0] P_FUNC_RST = 8'h80
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_HSEL,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic I_HREADY,
	input wire logic O_HREADYOUT,
	input wire logic O_HRESP,
	input wire logic [31:0] O_HRDATA,
	input wire logic [7:0] O_PIN_DIR,
	input wire logic [7:0] O_HW_FUNC,
	input wire logic [7:0] O_PIN_IRQ,
	input wire logic O_PORT_IRQ,
	input wire logic O_CONV_TRIG
);
	// ********************
	// Properties
	// ********************
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	logic take;
	assign take = I_HSEL && I_HTRANS[1] && I_HREADY;
	a_port_or: assert property (O_PORT_IRQ == |O_PIN_IRQ)
		else $error("combined irq differs from OR of pin irqs");
	a_trig_follows: assert property ($rose(O_PIN_IRQ[4]) |=> O_CONV_TRIG)
		else $error("no trigger after pin 4 irq rose");
	a_trig_single: assert property (O_CONV_TRIG |=> !O_CONV_TRIG)
		else $error("trigger longer than one cycle");
	a_trig_cause: assert property (O_CONV_TRIG |-> $past(O_PIN_IRQ[4]) && !$past(O_PIN_IRQ[4], 2))
		else $error("trigger without a pin 4 irq onset");
	a_rsvd_zero: assert property (O_HREADYOUT |-> O_HRDATA[31:8] == 24'h000000)
		else $error("reserved read bits not zero");
	a_resp_okay: assert property (O_HRESP == 1'b0)
		else $error("bus response not okay");
	a_read_wait: assert property (take && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
		else $error("read data phase not one wait state");
	a_write_ready: assert property (take && I_HWRITE |=> O_HREADYOUT)
		else $error("write data phase stalled");
	a_rst_func: assert property (disable iff (1'b0) I_RST |-> O_HW_FUNC == P_FUNC_RST && O_PIN_DIR == 8'h00)
		else $error("function or direction not at default in reset");
	a_rst_irq: assert property (disable iff (1'b0) I_RST |-> O_PIN_IRQ == 8'h00 && !O_CONV_TRIG)
		else $error("irq outputs active in reset");
endmodule
bind gpi_top gpi_top_chk #(.P_FUNC_RST(P_FUNC_RST)) u_gpi_top_chk (.I_CLK, .I_RST, .I_HSEL,
	.I_HTRANS, .I_HWRITE, .I_HREADY, .O_HREADYOUT, .O_HRESP, .O_HRDATA, .O_PIN_DIR,
	.O_HW_FUNC, .O_PIN_IRQ, .O_PORT_IRQ, .O_CONV_TRIG);
`default_nettype wire

/* File: sim/gpi_pin_model.sv */
// Pin-side partner: drives port pins and counts converter triggers
`timescale 1ns/10ps
`default_nettype none
module gpi_pin_model (
	input wire logic i_clk,
	input wire logic [7:0] i_lvl,
	input wire logic i_trig,
	output logic [7:0] o_pin,
	output int o_trig_cnt
);
	// ********************
	// Pins and trigger input
	// ********************
	initial o_pin = 8'h00;
	initial o_trig_cnt = 0;
	// Pins move only after an edge, synchronous as the block expects
	always @(posedge i_clk) begin
		o_pin <= i_lvl;
		if (i_trig) begin
			o_trig_cnt <= o_trig_cnt + 1;
		end
	end
endmodule
`default_nettype wire

/* File: sim/tb_gpi_top.sv */
// Self-checking bench for the port interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb_gpi_top;
	import gpi_pkg::*;
	// ********************
	// Harness
	// ********************
	logic clk = 1'b0;
	logic rst;
	logic sel = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [1:0] trans = 2'h0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [7:0] lvl = 8'h00;
	logic rdy, resp, conv, pport;
	logic [31:0] rdata;
	logic [7:0] pin, dir, func, pirq;
	int trig_cnt, error_cnt = 0, tests_run = 0, cyc = 0;
	always #2.5 clk = ~clk;
	gpi_top u_gpi_top (.I_CLK(clk), .I_RST(rst), .I_HSEL(sel), .I_HADDR(addr), .I_HTRANS(trans),
		.I_HWRITE(wr_en), .I_HSIZE(3'h2), .I_HWDATA(wdata), .I_HREADY(rdy), .O_HREADYOUT(rdy),
		.O_HRESP(resp), .O_HRDATA(rdata), .I_PIN(pin), .O_PIN_DIR(dir), .O_HW_FUNC(func),
		.O_PIN_IRQ(pirq), .O_PORT_IRQ(pport), .O_CONV_TRIG(conv));
	gpi_pin_model u_gpi_pin_model (.i_clk(clk), .i_lvl(lvl), .i_trig(conv), .o_pin(pin),
		.o_trig_cnt(trig_cnt));
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Run is well under 2000 cycles; ceiling leaves margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Master holds each phase until hready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		sel <= 1'b1;
		trans <= 2'h2;
		wr_en <= w;
		addr <= {20'h0, a};
		do @(posedge clk); while (rdy !== 1'b1);
		trans <= 2'h0;
		wdata <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		q = rdata;
		sel <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// ********************
	// Scenarios
	// ********************
	task automatic t_reset;
		rd(OFF_BOTH, 32'h0, "both");
		rd(OFF_POL, 32'h0, "pol");
		rd(OFF_MASK, 32'h0, "mask");
		rd(OFF_RAW, 32'h0, "raw");
		rd(OFF_FUNC, 32'h80, "func");
		chk("hw_func", 32'h80, {24'h0, func});
		$display("t_reset done");
	endtask
	task automatic edge_case(input logic [7:0] both, pol, from, to, e);
		wr(OFF_BOTH, {24'h0, both});
		wr(OFF_POL, {24'h0, pol});
		lvl <= from;
		settle(3);
		wr(OFF_CLR, 32'hFF);
		lvl <= to;
		settle(3);
		rd(OFF_RAW, {24'h0, e}, "raw");
		rd(OFF_MIS, {24'h0, e & 8'h0F}, "mis");
		chk("pin_irq", {24'h0, e & 8'h0F}, {24'h0, pirq});
		wr(OFF_CLR, 32'hFFFF_FF0F);
		rd(OFF_RAW, {24'h0, e & 8'hF0}, "raw_clr");
	endtask
	task automatic t_edge;
		wr(OFF_MASK, 32'h0F);
		edge_case(8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF);
		edge_case(8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF);
		edge_case(8'h0F, 8'hF0, 8'hFF, 8'h00, 8'h0F);
		edge_case(8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF);
		edge_case(8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00);
		edge_case(8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF);
		edge_case(8'h00, 8'h00, 8'h00, 8'hFF, 8'h00);
		rd(OFF_CLR, 32'h0, "clr_read");
		// Falling edge of pin 0 lands on the clear's write edge; the new edge must win
		fork
			wr(OFF_CLR, 32'h01);
			begin
				@(posedge clk);
				lvl <= 8'hFE;
			end
		join
		rd(OFF_RAW, 32'h01, "set_wins");
		$display("t_edge done");
	endtask
	task automatic t_level;
		wr(OFF_SENSE, 32'hFF);
		rd(OFF_SENSE, 32'hFF, "sense");
		wr(OFF_POL, 32'h0F);
		lvl <= 8'h3C;
		settle(3);
		rd(OFF_RAW, 32'hCC, "lvl_raw");
		wr(OFF_CLR, 32'hFF);
		rd(OFF_RAW, 32'hCC, "lvl_noclr");
		lvl <= 8'h00;
		settle(3);
		rd(OFF_RAW, 32'hF0, "lvl_follow");
		wr(OFF_SENSE, 32'h0);
		$display("t_level done");
	endtask
	task automatic t_trig;
		int n0;
		wr(OFF_POL, 32'hFF);
		wr(OFF_MASK, 32'h10);
		wr(OFF_CLR, 32'hFF);
		n0 = trig_cnt;
		lvl <= 8'h10;
		settle(6);
		chk("trig", n0 + 1, trig_cnt);
		chk("port_irq", 32'h1, {31'h0, pport});
		wr(OFF_MASK, 32'h0);
		settle(1);
		chk("port_off", 32'h0, {31'h0, pport});
		wr(OFF_CLR, 32'hFF);
		lvl <= 8'h00;
		settle(3);
		lvl <= 8'h10;
		settle(6);
		chk("trig_masked", n0 + 1, trig_cnt);
		rd(OFF_RAW, 32'h10, "raw_masked");
		$display("t_trig done");
	endtask
	task automatic t_func;
		wr(OFF_FUNC, 32'hFFFF_FF55);
		rd(OFF_FUNC, 32'h55, "func_wr");
		chk("hw_func", 32'h55, {24'h0, func});
		rd(12'h800, 32'h0, "unmapped");
		wr(OFF_DIR, 32'hA5);
		rd(OFF_DIR, 32'hA5, "dir_rd");
		chk("dir_wr", 32'hA5, {24'h0, dir});
		// Reset hands the debug pins back, so a debugger can attach
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle(1);
		chk("func_rst", 32'h80, {24'h0, func});
		chk("dir_rst", 32'h0, {24'h0, dir});
		rd(OFF_MASK, 32'h0, "mask_rst");
		$display("t_func done");
	endtask
	initial begin
		// Edge at time zero so the asynchronous reset acts before the first clock
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_edge();
		t_level();
		t_trig();
		t_func();
		results();
	end
endmodule
`default_nettype wire
